// *** src/servo_monitor_pkg.sv ***
// Purpose: shared constants and types of the monitor and instruction handshake block
// Assumes: 32-bit AXI4-Lite register bus, 16-bit remote words
// Notes: every offset, field position and code lives here, with the reset values of the control, mask and word registers
package servo_monitor_pkg;
  // widths
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int MON_W = 32;
  localparam int ADDR_W = 8;
  localparam int STN_W = 8;
  localparam int RW_COUNT = 7;
  localparam int WW_COUNT = 3;
  localparam int IRQ_W = 2;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_WW_BASE = 8'h10;
  localparam logic [7:0] OFS_RW_BASE = 8'h20;
  // control field positions
  localparam int CTRL_MON_REQ = 0;
  localparam int CTRL_EXEC_REQ = 1;
  localparam int CTRL_TWO_STN = 2;
  localparam int CTRL_STN_LSB = 8;
  // status field positions
  localparam int ST_ACK = 0;
  localparam int ST_DONE = 1;
  localparam int ST_MON_ERR = 2;
  localparam int ST_INSTR_ERR = 3;
  // interrupt event positions
  localparam int EV_ACK = 0;
  localparam int EV_DONE = 1;
  // remote word indices
  localparam int WW_MON1 = 0;
  localparam int WW_MON2_ONE = 1;
  localparam int WW_MON2_TWO = 2;
  localparam int WW_INSTR = 2;
  localparam int RW_MON1_LO = 0;
  localparam int RW_SECOND = 1;
  localparam int RW_RESP = 2;
  localparam int RW_MON2_LO = 5;
  localparam int RW_MON2_HI = 6;
  // respond codes and bus answers
  localparam logic [15:0] RESP_OK = 16'h0000;
  localparam logic [15:0] RESP_ERR = 16'h0001;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  typedef enum logic [2:0] {
    INSTR_IDLE = 3'b001,
    INSTR_RUN = 3'b010,
    INSTR_DONE = 3'b100
  } instr_state_t;
endpackage

// *** src/monitor_sel_if.sv ***
// Purpose: carries one monitor selection and its answer between core and selector
// Assumes: single clock domain
// Notes: valid marks data registered from an enabled cycle
`timescale 1ns/1ps
interface monitor_sel_if import servo_monitor_pkg::*; ();
  logic [WORD_W-1:0] code;
  logic en;
  logic valid;
  logic [MON_W-1:0] data;
  logic err;
  modport mux (input code, input en, output valid, output data, output err);
  modport user (output code, output en, input valid, input data, input err);
endinterface

// *** src/monitor_select.sv ***
// Purpose: picks one monitor value by code and registers it
// Assumes: monitor values come from logic on the same clock
// Notes: a code past the last channel answers zero data with err set
`timescale 1ns/1ps
module monitor_select import servo_monitor_pkg::*; #(
  parameter int MON_COUNT = 8
) (
  input logic aclk, // system clock
  input logic aresetn, // synchronous reset, active low
  input logic ce, // clock enable, freezes state when low
  input logic [MON_COUNT*MON_W-1:0] mon_values, // all monitor channels, flattened
  monitor_sel_if.mux sel // selection and answer
);
  localparam int SEL_W = $clog2(MON_COUNT);
  logic [MON_W-1:0] data_reg, data_next;
  logic err_reg, err_next;
  logic valid_reg, valid_next;
  logic [SEL_W-1:0] idx;

  // hold last value while disabled so the words do not flicker
  always_comb begin
    idx = sel.code[SEL_W-1:0];
    data_next = data_reg;
    err_next = err_reg;
    valid_next = sel.en;
    if (sel.en) begin
      if (sel.code < WORD_W'(MON_COUNT)) begin
        data_next = mon_values[idx*MON_W +: MON_W];
        err_next = 1'b0;
      end else begin
        data_next = '0;
        err_next = 1'b1;
      end
    end
  end

  // register the selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_reg <= '0;
      err_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else if (ce) begin
      data_reg <= data_next;
      err_reg <= err_next;
      valid_reg <= valid_next;
    end
  end

  assign sel.data = data_reg;
  assign sel.err = err_reg;
  assign sel.valid = valid_reg;
endmodule

// *** src/servo_monitor_command_handshake.sv ***
// Purpose: monitor-output and instruction-execution handshake of a remote station
// Assumes: the master works through AXI4-Lite; servo core shares aclk
// Notes: one refresh is one enabled clock cycle
// Contract
// (R1) monitor request loads words, raises acknowledge
// (R2) words refresh every cycle while request held
// (R3) one station: monitor-1 code word0, read word0
// (R4) one station: monitor-2 code word1, read word1
// (R5) read word2 carries monitor normal/error code
// (R6) two stations: monitor-1 upper half at word1
// (R7) two stations: monitor-2 code word2, low word5
// (R8) two stations: monitor-2 upper half at word6
// (R9) execute request runs code from write word2
// (R10) finish posts respond code, raises completion
// (R11) master sets station number select bits
// (R12) two stations: monitor-1 lower half at word0
// (R13) master waits for acknowledge before reading
`timescale 1ns/1ps
module servo_monitor_command_handshake import servo_monitor_pkg::*; #(
  parameter int MON_COUNT = 8
) (
  input logic aclk, // system clock, 100 MHz
  input logic aresetn, // synchronous reset, active low
  input logic ce, // clock enable
  input logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input logic [DATA_W-1:0] s_axi_wdata, // write data
  input logic [3:0] s_axi_wstrb, // write byte strobes
  input logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input logic s_axi_bready, // write response ready
  input logic [ADDR_W-1:0] s_axi_araddr, // read address
  input logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input logic s_axi_rready, // read ready
  input logic [MON_COUNT*MON_W-1:0] mon_values, // monitor channels from servo core
  output logic instr_start, // one-cycle start of instruction
  output logic [WORD_W-1:0] instr_code, // instruction code being run
  input logic instr_finish, // servo core finished the instruction
  input logic instr_error, // finished with error, valid with finish
  output logic [STN_W-1:0] station_select, // station number bits from master
  output logic irq // level interrupt
);
  // register state
  logic [31:0] ctrl_reg, ctrl_next;
  logic [IRQ_W-1:0] irq_st_reg, irq_st_next;
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [WORD_W-1:0] ww_reg [WW_COUNT];
  logic [WORD_W-1:0] ww_next [WW_COUNT];
  logic [WORD_W-1:0] rw_reg [RW_COUNT];
  logic [WORD_W-1:0] rw_next [RW_COUNT];
  // bus state
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [DATA_W-1:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  // handshake state
  logic mon_ack_reg, mon_ack_next, mon_err_reg, mon_err_next;
  logic exec_done_reg, exec_done_next, instr_err_reg, instr_err_next;
  logic instr_start_reg, instr_start_next;
  logic [WORD_W-1:0] instr_code_reg, instr_code_next;
  instr_state_t instr_state_reg, instr_state_next;
  // helpers
  logic aw_ok, w_ok, do_write, wr_hit;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic rd_hit, mon_req, exec_req, two_stn, mon_load, finish_now;
  logic [IRQ_W-1:0] ev;

  monitor_sel_if mon1 ();
  monitor_sel_if mon2 ();

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  assign mon_req = ctrl_reg[CTRL_MON_REQ];
  assign exec_req = ctrl_reg[CTRL_EXEC_REQ];
  assign two_stn = ctrl_reg[CTRL_TWO_STN];
  assign station_select = ctrl_reg[CTRL_STN_LSB +: STN_W];

  // selectors run only while the request stands
  // (R7) second code word
  assign mon1.code = ww_reg[WW_MON1];
  assign mon2.code = two_stn ? ww_reg[WW_MON2_TWO] : ww_reg[WW_MON2_ONE];
  assign mon1.en = mon_req;
  assign mon2.en = mon_req;
  assign mon_load = mon_req && mon1.valid && mon2.valid;
  assign finish_now = (instr_state_reg == INSTR_RUN) && instr_finish;

  monitor_select #(.MON_COUNT(MON_COUNT)) u_mon1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .mon_values(mon_values),
    .sel(mon1)
  );
  monitor_select #(.MON_COUNT(MON_COUNT)) u_mon2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .mon_values(mon_values),
    .sel(mon2)
  );

  // ready terms include ce so nothing is taken while frozen
  assign s_axi_awready = ce && !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = ce && !w_got_reg && !bvalid_reg;
  assign s_axi_arready = ce && !rvalid_reg;
  assign aw_ok = aw_got_reg || (s_axi_awvalid && s_axi_awready);
  assign w_ok = w_got_reg || (s_axi_wvalid && s_axi_wready);
  assign do_write = aw_ok && w_ok && !bvalid_reg;
  assign wr_addr = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data = w_got_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb = w_got_reg ? w_strb_reg : s_axi_wstrb;

  // read decode; read-only status and remote words sit beside the controls
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFS_CTRL: rd_data = ctrl_reg;
      OFS_STATUS: rd_data = 32'({instr_err_reg, mon_err_reg, exec_done_reg, mon_ack_reg});
      OFS_IRQ_ST: rd_data = 32'(irq_st_reg);
      OFS_IRQ_MASK: rd_data = 32'(irq_mask_reg);
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < WW_COUNT; i++) begin
          if (s_axi_araddr == OFS_WW_BASE + ADDR_W'(4 * i)) begin
            rd_data = 32'(ww_reg[i]);
            rd_hit = 1'b1;
          end
        end
        for (int i = 0; i < RW_COUNT; i++) begin
          if (s_axi_araddr == OFS_RW_BASE + ADDR_W'(4 * i)) begin
            rd_data = 32'(rw_reg[i]);
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  // bus channel state; writes to read-only words are ignored with OKAY
  always_comb begin
    aw_got_next = aw_got_reg;
    aw_addr_next = aw_addr_reg;
    w_got_next = w_got_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    wr_hit = (wr_addr < OFS_RW_BASE + ADDR_W'(4 * RW_COUNT)) && (wr_addr[1:0] == 2'h0);
    if (do_write) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? AXI_OKAY : AXI_SLVERR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_next = 1'b1;
        aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_next = 1'b1;
        w_data_next = s_axi_wdata;
        w_strb_next = s_axi_wstrb;
      end
    end
    if (bvalid_reg && s_axi_bready) bvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next = rd_data;
      rresp_next = rd_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // software registers and interrupt status; a new event beats a clear
  always_comb begin
    ctrl_next = ctrl_reg;
    irq_mask_next = irq_mask_reg;
    ww_next = ww_reg;
    irq_st_next = irq_st_reg;
    if (do_write) begin
      if (wr_addr == OFS_CTRL) ctrl_next = merge(ctrl_reg, wr_data, wr_strb);
      if (wr_addr == OFS_IRQ_MASK) begin
        irq_mask_next = IRQ_W'(merge(32'(irq_mask_reg), wr_data, wr_strb));
      end
      if (wr_addr == OFS_IRQ_ST && wr_strb[0]) irq_st_next = irq_st_reg & ~wr_data[IRQ_W-1:0];
      for (int i = 0; i < WW_COUNT; i++) begin
        if (wr_addr == OFS_WW_BASE + ADDR_W'(4 * i)) begin
          ww_next[i] = WORD_W'(merge(32'(ww_reg[i]), wr_data, wr_strb));
        end
      end
    end
    irq_st_next = irq_st_next | ev;
  end

  assign ev[EV_ACK] = mon_ack_next && !mon_ack_reg;
  assign ev[EV_DONE] = exec_done_next && !exec_done_reg;
  assign irq = |(irq_st_reg & irq_mask_reg);

  // monitor path: ack follows the first load and drops with the request
  always_comb begin
    rw_next = rw_reg;
    mon_ack_next = mon_ack_reg;
    mon_err_next = mon_err_reg;
    if (!mon_req) begin
      mon_ack_next = 1'b0;
    end else if (mon_load) begin
      // (R1) load and acknowledge
      // (R2) reload every cycle
      mon_ack_next = 1'b1;
      mon_err_next = mon1.err || mon2.err;
      // (R3) (R12) monitor-1 low half
      rw_next[RW_MON1_LO] = mon1.data[WORD_W-1:0];
      // (R4) (R6) second read word
      rw_next[RW_SECOND] = two_stn ? mon1.data[MON_W-1:WORD_W] : mon2.data[WORD_W-1:0];
      // (R7) (R8) two-station monitor-2 halves
      rw_next[RW_MON2_LO] = two_stn ? mon2.data[WORD_W-1:0] : WORD_RST;
      rw_next[RW_MON2_HI] = two_stn ? mon2.data[MON_W-1:WORD_W] : WORD_RST;
      // (R5) monitor respond code
      rw_next[RW_RESP] = (mon1.err || mon2.err) ? RESP_ERR : RESP_OK;
    end
    // (R10) instruction respond code wins its refresh
    if (finish_now) rw_next[RW_RESP] = instr_error ? RESP_ERR : RESP_OK;
  end

  // instruction sequencer; a request dropped mid-run still completes
  always_comb begin
    instr_state_next = instr_state_reg;
    instr_start_next = 1'b0;
    instr_code_next = instr_code_reg;
    exec_done_next = exec_done_reg;
    instr_err_next = instr_err_reg;
    case (instr_state_reg)
      INSTR_IDLE: begin
        // (R9) start with word2 code
        if (exec_req) begin
          instr_start_next = 1'b1;
          instr_code_next = ww_reg[WW_INSTR];
          instr_state_next = INSTR_RUN;
        end
      end
      INSTR_RUN: begin
        // (R10) raise completion
        if (instr_finish) begin
          exec_done_next = 1'b1;
          instr_err_next = instr_error;
          instr_state_next = INSTR_DONE;
        end
      end
      INSTR_DONE: begin
        if (!exec_req) begin
          exec_done_next = 1'b0;
          instr_state_next = INSTR_IDLE;
        end
      end
      default: begin
        instr_state_next = INSTR_IDLE;
        exec_done_next = 1'b0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
      irq_st_reg <= '0;
      irq_mask_reg <= IRQ_MASK_RST;
      for (int i = 0; i < WW_COUNT; i++) ww_reg[i] <= WORD_RST;
      for (int i = 0; i < RW_COUNT; i++) rw_reg[i] <= WORD_RST;
      aw_got_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_got_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= AXI_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= AXI_OKAY;
      rdata_reg <= '0;
      mon_ack_reg <= 1'b0;
      mon_err_reg <= 1'b0;
      exec_done_reg <= 1'b0;
      instr_err_reg <= 1'b0;
      instr_start_reg <= 1'b0;
      instr_code_reg <= WORD_RST;
      instr_state_reg <= INSTR_IDLE;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      irq_st_reg <= irq_st_next;
      irq_mask_reg <= irq_mask_next;
      ww_reg <= ww_next;
      rw_reg <= rw_next;
      aw_got_reg <= aw_got_next;
      aw_addr_reg <= aw_addr_next;
      w_got_reg <= w_got_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      mon_ack_reg <= mon_ack_next;
      mon_err_reg <= mon_err_next;
      exec_done_reg <= exec_done_next;
      instr_err_reg <= instr_err_next;
      instr_start_reg <= instr_start_next;
      instr_code_reg <= instr_code_next;
      instr_state_reg <= instr_state_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign instr_start = instr_start_reg;
  assign instr_code = instr_code_reg;

  // checks; a frozen cycle aborts any attempt in flight
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  sequence s_req_rise;
    $rose(mon_req) ##1 mon_req;
  endsequence
  sequence s_one_load;
    $past(mon_load) && !$past(two_stn);
  endsequence
  sequence s_two_load;
    $past(mon_load) && $past(two_stn);
  endsequence

  property p_mon_ack;
    s_req_rise |-> !mon_ack_reg ##1 (mon_ack_reg && rw_reg[RW_MON1_LO] == $past(mon1.data[15:0]));
  endproperty
  a_mon_ack: assert property (p_mon_ack) else $error("ack not raised with loaded words"); // R1
  property p_mon_refresh;
    mon_req [*3] |-> rw_reg[RW_MON1_LO] == $past(mon1.data[15:0]) && mon_ack_reg;
  endproperty
  a_mon_refresh: assert property (p_mon_refresh) else $error("words not refreshed"); // R2
  property p_one_mon1;
    s_one_load |-> rw_reg[RW_MON1_LO] == $past(mon1.data[15:0]);
  endproperty
  a_one_mon1: assert property (p_one_mon1) else $error("word0 wrong, one station"); // R3
  property p_one_mon2;
    s_one_load |-> rw_reg[RW_SECOND] == $past(mon2.data[15:0]);
  endproperty
  a_one_mon2: assert property (p_one_mon2) else $error("word1 wrong, one station"); // R4
  property p_mon_resp;
    $past(mon_load) && !$past(finish_now) |->
      rw_reg[RW_RESP] == (($past(mon1.err) || $past(mon2.err)) ? RESP_ERR : RESP_OK);
  endproperty
  a_mon_resp: assert property (p_mon_resp) else $error("monitor respond code wrong"); // R5
  property p_two_mon1_hi;
    s_two_load |-> rw_reg[RW_SECOND] == $past(mon1.data[31:16]);
  endproperty
  a_two_mon1_hi: assert property (p_two_mon1_hi) else $error("word1 wrong, two stations"); // R6
  property p_two_mon2_lo;
    s_two_load |-> rw_reg[RW_MON2_LO] == $past(mon2.data[15:0]) &&
      (!$past(two_stn, 2) || $past(mon2.code == ww_reg[WW_MON2_TWO], 2));
  endproperty
  a_two_mon2_lo: assert property (p_two_mon2_lo) else $error("word5 wrong"); // R7
  property p_two_mon2_hi;
    s_two_load |-> rw_reg[RW_MON2_HI] == $past(mon2.data[31:16]);
  endproperty
  a_two_mon2_hi: assert property (p_two_mon2_hi) else $error("word6 wrong"); // R8
  property p_two_mon1_lo;
    s_two_load |-> rw_reg[RW_MON1_LO] == $past(mon1.data[15:0]);
  endproperty
  a_two_mon1_lo: assert property (p_two_mon1_lo) else $error("word0 wrong, two stations"); // R12
  property p_instr_start;
    (instr_state_reg == INSTR_IDLE) && exec_req |=>
      instr_start_reg && instr_code_reg == $past(ww_reg[2]) ##1 !instr_start_reg;
  endproperty
  a_instr_start: assert property (p_instr_start) else $error("instruction start wrong"); // R9
  property p_instr_done;
    finish_now |=> exec_done_reg && rw_reg[RW_RESP] == ($past(instr_error) ? RESP_ERR : RESP_OK);
  endproperty
  a_instr_done: assert property (p_instr_done) else $error("completion not posted"); // R10
endmodule

// *** verification/servo_core_model.sv ***
// Purpose: stand-in for the servo core behind the handshake block
// Assumes: same clock as the block; DELAY of at least 2
// Notes: code bit 15 marks an instruction that finishes with error
`timescale 1ns/1ps
module servo_core_model import servo_monitor_pkg::*; #(
  parameter int MON_COUNT = 8,
  parameter int DELAY = 3
) (
  input logic aclk, // system clock
  input logic aresetn, // synchronous reset, active low
  input logic [15:0] base, // low half seed of every channel
  input logic instr_start, // start pulse from the block
  input logic [WORD_W-1:0] instr_code, // code being run
  output logic [MON_COUNT*MON_W-1:0] mon_values, // monitor channels
  output logic instr_finish, // one-cycle completion pulse
  output logic instr_error // valid only with finish
);
  int cnt;
  // channel i: upper half marks the channel, lower half follows base
  always_comb begin
    for (int i = 0; i < MON_COUNT; i++) begin
      mon_values[i*MON_W+:MON_W] = {16'hA000 | 16'(i), base + 16'(i)};
    end
  end
  // error line toggles outside finish so a stale level is never trusted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      instr_finish <= 1'b0;
      instr_error <= 1'b0;
    end else begin
      cnt <= instr_start ? DELAY : (cnt > 0 ? cnt - 1 : 0);
      instr_finish <= (cnt == 1);
      instr_error <= (cnt == 1) ? instr_code[15] : ~instr_error;
    end
  end
endmodule

// *** verification/testbench.sv ***
// Purpose: register-level test of the monitor and instruction handshake
// Assumes: AXI4-Lite master tasks, core stand-in model
// Notes: monitor words lag the channels by two cycles
`timescale 1ns/1ps
module testbench import servo_monitor_pkg::*;;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata;
  logic [255:0] mon_values;
  logic instr_start, instr_finish, instr_error, irq;
  logic [15:0] instr_code, base = 16'h0100, last_code = 16'h0;
  logic [7:0] station_select;
  int mismatches = 0, checks_done = 0;
  servo_monitor_command_handshake dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mon_values, .instr_start, .instr_code,
    .instr_finish, .instr_error, .station_select, .irq);
  servo_core_model core (.aclk, .aresetn, .base, .instr_start, .instr_code, .mon_values,
    .instr_finish, .instr_error);
  // clock and start-pulse capture
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (instr_start === 1'b1) last_code <= instr_code;
  function automatic logic [31:0] mlo(int i);
    return 32'(base + 16'(i));
  endfunction
  function automatic logic [31:0] mhi(int i);
    return 32'(16'hA000 | 16'(i));
  endfunction
  function automatic logic [7:0] rw(int i);
    return OFS_RW_BASE + 8'(4 * i);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // each channel released at the edge that takes it; bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    // a response that never came counts against the run
    chk(32'(s_axi_bvalid), 32'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    chk(32'(s_axi_rvalid), 32'h1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // waits for a status bit in the mask (acknowledge or completion) before the first monitor words and each instruction respond code are read back
  // poll before reading
  task automatic poll(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      rd(OFS_STATUS, d);
      n++;
    end while ((d & m) == 0 && n < 50);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    print_verdict();
  end
  // test sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL, d); chk(d, CTRL_RST);
    rd(OFS_IRQ_MASK, d); chk(d, 32'(IRQ_MASK_RST));
    rd(8'h3C, d); chk({d[31:2], r}, {30'h0, AXI_SLVERR});
    wr(rw(0), 32'h0000_FFFF);
    chk(32'(r), 32'(AXI_OKAY));
    wr(8'h3C, 32'h0000_0001);
    chk(32'(r), 32'(AXI_SLVERR));
    rd(rw(0), d); chk(d, 32'h0);
    wr(OFS_IRQ_MASK, 32'h3);
    wr(OFS_WW_BASE, 32'h2);
    wr(OFS_WW_BASE + 8'h04, 32'h5);
    wr(OFS_CTRL, 32'h0000_5A01);
    poll(32'h1); chk(d & 32'h1, 32'h1);
    rd(rw(0), d); chk(d, mlo(2));
    rd(rw(1), d); chk(d, mlo(5));
    rd(rw(2), d); chk(d, 32'(RESP_OK));
    chk(32'(station_select), 32'h5A);
    chk(32'(irq), 32'h1);
    // frozen block takes nothing from the bus; words catch up after ce returns
    ce <= 1'b0;
    base <= 16'h0300;
    repeat (4) @(posedge aclk);
    chk(32'(s_axi_arready), 32'h0);
    chk(32'(s_axi_awready), 32'h0);
    chk(32'(irq), 32'h1);
    ce <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(rw(0), d); chk(d, mlo(2));
    wr(OFS_IRQ_ST, 32'h1);
    rd(OFS_IRQ_ST, d); chk(d & 32'h1, 32'h0);
    chk(32'(irq), 32'h0);
    wr(OFS_WW_BASE + 8'h08, 32'h1);
    wr(OFS_WW_BASE, 32'h3);
    wr(OFS_CTRL, 32'h0000_5A05);
    repeat (4) @(posedge aclk);
    rd(rw(0), d); chk(d, mlo(3));
    rd(rw(1), d); chk(d, mhi(3));
    rd(rw(5), d); chk(d, mlo(1));
    rd(rw(6), d); chk(d, mhi(1));
    wr(OFS_WW_BASE, 32'h8);
    repeat (4) @(posedge aclk);
    rd(rw(2), d); chk(d, 32'(RESP_ERR));
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, d); chk(d & 32'h1, 32'h0);
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_WW_BASE + 8'h08, 32'h0012);
    wr(OFS_CTRL, 32'h2);
    poll(32'h2); chk(d & 32'hA, 32'h2);
    chk(32'(last_code), 32'h0012);
    rd(rw(2), d); chk(d, 32'(RESP_OK));
    rd(OFS_IRQ_ST, d); chk(d & 32'h2, 32'h2);
    chk(32'(irq), 32'h0);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, d); chk(d & 32'h2, 32'h0);
    wr(OFS_WW_BASE + 8'h08, 32'h8034);
    wr(OFS_CTRL, 32'h2);
    poll(32'h2); chk(d & 32'hA, 32'hA);
    chk(32'(last_code), 32'h8034);
    rd(rw(2), d); chk(d, 32'(RESP_ERR));
    print_verdict();
  end
endmodule
